// ==== hbi_pkg.sv ====
package hbi_pkg;

   // ==========================================================
   // widths
   // ==========================================================
   localparam int ADDR_W   = 8;
   localparam int QUAD_W   = 32;
   localparam int BYTE_W   = 8;
   localparam int LANES    = 4;
   localparam int QIDX_W   = 6;
   localparam int PIN_W    = 31;

   // ==========================================================
   // field positions inside the synchronised pin vector
   // ==========================================================
   localparam int PIN_SEL  = 30;
   localparam int PIN_WR   = 29;
   localparam int PIN_RD   = 28;
   localparam int PIN_ALE  = 27;
   localparam int PIN_FLAG = 26;
   localparam int PIN_WID  = 25;
   localparam int PIN_MUX  = 24;
   localparam int PIN_ADDR = 16;
   localparam int PIN_ADLO = 8;
   localparam int PIN_DHI  = 0;

   // ==========================================================
   // reset values and 16-bit byte enables
   // ==========================================================
   // select and read/write strobes idle high, address latch strobe idles low
   localparam logic [PIN_W-1:0]  PIN_RST  = 31'h7000_0000;
   localparam logic [QUAD_W-1:0] QUAD_RST = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [LANES-1:0]  BE_LO16  = 4'h3;
   localparam logic [LANES-1:0]  BE_HI16  = 4'hc;

   typedef enum logic [1:0] {
      HBI_IDLE,
      HBI_READ_WAIT,
      HBI_WRITE_WAIT,
      HBI_HOLD
   } hbi_state_t;

endpackage

// ==== hbi_host_port.sv ====
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RL1 - low byte lanes carry all register data; in wide mode odd lanes use the upper lines
// RL2 - upper lanes used only in wide mode
// RL3 - boundary flag triggers quadlet fetch or store
// RL4 - strobes ignored unless select is low; the address latch strobe is taken regardless of select
// RL5 - write strobe wins over read strobe
// RL6 - read strobe alone reads addressed register
// RL7 - open-drain interrupt low while any pending
// RL8 - latch strobe captures address in mux mode
// RL9 - stall high while access not complete
// RL10 - master reset acts asynchronously
// RL11 - width select picks 8 or 16 bits
// RL12 - mux select picks shared or separate address
// RL13 - staged quadlets keep internal updates atomic
module hbi_host_port
   import hbi_pkg::*;
(
   input  wire logic                clock_in,
   input  wire logic                rst_b_in,
   input  wire logic                master_reset_n_in,
   input  wire logic                host_select_n_in,
   input  wire logic                host_write_strobe_n_in,
   input  wire logic                host_read_strobe_n_in,
   input  wire logic                address_latch_strobe_in,
   input  wire logic                quadlet_boundary_flag_in,
   input  wire logic                width_select_in,
   input  wire logic                multiplex_select_in,
   input  wire logic [ADDR_W-1:0]   host_addr_low_in,
   input  wire logic [BYTE_W-1:0]   host_addr_data_low_in,
   output logic      [BYTE_W-1:0]   host_addr_data_low_out,
   output logic                     host_addr_data_low_oe_out,
   input  wire logic [BYTE_W-1:0]   host_data_high_in,
   output logic      [BYTE_W-1:0]   host_data_high_out,
   output logic                     host_data_high_oe_out,
   output logic                     host_stall_out,
   output logic                     host_irq_n_out,
   output logic                     host_irq_n_oe_out,
   output logic      [QIDX_W-1:0]   reg_addr_out,
   output logic      [QUAD_W-1:0]   reg_wdata_out,
   output logic                     reg_wr_out,
   output logic                     reg_rd_out,
   input  wire logic [QUAD_W-1:0]   reg_rdata_in,
   input  wire logic                reg_ack_in,
   input  wire logic                irq_pending_in
);

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   logic [PIN_W-1:0]  pin_raw;
   logic [PIN_W-1:0]  pin_meta_q;
   logic [PIN_W-1:0]  pin_q;

   assign pin_raw = {host_select_n_in, host_write_strobe_n_in,
                     host_read_strobe_n_in, address_latch_strobe_in,
                     quadlet_boundary_flag_in, width_select_in,
                     multiplex_select_in, host_addr_low_in,
                     host_addr_data_low_in, host_data_high_in};

   always_ff @(posedge clock_in or negedge master_reset_n_in) begin
      if (!master_reset_n_in) begin // [RL10]
         pin_meta_q <= PIN_RST;
         pin_q      <= PIN_RST;
      end else if (!rst_b_in) begin
         pin_meta_q <= PIN_RST;
         pin_q      <= PIN_RST;
      end else begin
         pin_meta_q <= pin_raw;
         pin_q      <= pin_meta_q;
      end
   end

   logic              sel_n;
   logic              wr_n;
   logic              rd_n;
   logic              ale;
   logic              flag;
   logic              wide;
   logic              muxed;
   logic [ADDR_W-1:0] addr_pin;
   logic [BYTE_W-1:0] ad_lo;
   logic [BYTE_W-1:0] d_hi;

   assign sel_n    = pin_q[PIN_SEL];
   assign wr_n     = pin_q[PIN_WR];
   assign rd_n     = pin_q[PIN_RD];
   assign ale      = pin_q[PIN_ALE];
   assign flag     = pin_q[PIN_FLAG];
   assign wide     = pin_q[PIN_WID];
   assign muxed    = pin_q[PIN_MUX];
   assign addr_pin = pin_q[PIN_ADDR +: ADDR_W];
   assign ad_lo    = pin_q[PIN_ADLO +: BYTE_W];
   assign d_hi     = pin_q[PIN_DHI +: BYTE_W];

   // ==========================================================
   // address capture
   // ==========================================================
   logic [ADDR_W-1:0] addr_latch_q;
   logic [ADDR_W-1:0] addr_eff;

   always_ff @(posedge clock_in or negedge master_reset_n_in) begin
      if (!master_reset_n_in) begin
         addr_latch_q <= ADDR_RST;
      end else if (!rst_b_in) begin
         addr_latch_q <= ADDR_RST;
      end else if (muxed && ale) begin // [RL8]
         addr_latch_q <= ad_lo;
      end
   end

   // shared lines in mux mode, separate pins otherwise
   assign addr_eff = muxed ? addr_latch_q : addr_pin; // [RL12]

   // ==========================================================
   // access decode
   // ==========================================================
   logic acc_go;
   logic acc_wr;
   logic acc_rel;

   assign acc_go  = !sel_n && (!wr_n || !rd_n); // [RL4]
   assign acc_wr  = !wr_n; // [RL5]
   assign acc_rel = sel_n || (wr_n && rd_n);

   // byte enables of the current lane
   logic [LANES-1:0] lane_be;

   always_comb begin
      if (wide) begin // [RL11]
         lane_be = addr_eff[1] ? BE_HI16 : BE_LO16;
      end else begin
         lane_be = LANES'(1) << addr_eff[1:0];
      end
   end

   // ==========================================================
   // write staging
   // ==========================================================
   logic [QUAD_W-1:0] wstage_q;
   logic [QUAD_W-1:0] wmerge;

   for (genvar i = 0; i < LANES; i++) begin : g_lane
      // odd lanes come from the upper lines only in wide mode
      assign wmerge[i*BYTE_W +: BYTE_W] =
         !lane_be[i]          ? wstage_q[i*BYTE_W +: BYTE_W] :
         (wide && (i % 2 == 1)) ? d_hi : ad_lo; // [RL1] [RL2]
   end

   // ==========================================================
   // sequencing
   // ==========================================================
   hbi_state_t state_q;
   logic       is_wr_q;

   always_ff @(posedge clock_in or negedge master_reset_n_in) begin
      if (!master_reset_n_in) begin
         state_q <= HBI_IDLE;
         is_wr_q <= 1'b0;
      end else if (!rst_b_in) begin
         state_q <= HBI_IDLE;
         is_wr_q <= 1'b0;
      end else begin
         unique case (state_q)
            HBI_IDLE: begin
               if (acc_go) begin
                  is_wr_q <= acc_wr;
                  if (!flag) begin
                     state_q <= HBI_HOLD;
                  end else if (acc_wr) begin
                     state_q <= HBI_WRITE_WAIT; // [RL3]
                  end else begin
                     state_q <= HBI_READ_WAIT; // [RL3]
                  end
               end
            end
            HBI_READ_WAIT,
            HBI_WRITE_WAIT: begin
               if (reg_ack_in) begin
                  state_q <= HBI_HOLD;
               end
            end
            HBI_HOLD: begin
               if (acc_rel) begin
                  state_q <= HBI_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // staged quadlets
   // ==========================================================
   logic [QUAD_W-1:0] rstage_q;

   always_ff @(posedge clock_in or negedge master_reset_n_in) begin
      if (!master_reset_n_in) begin
         wstage_q <= QUAD_RST;
         rstage_q <= QUAD_RST;
      end else if (!rst_b_in) begin
         wstage_q <= QUAD_RST;
         rstage_q <= QUAD_RST;
      end else begin
         if (state_q == HBI_IDLE && acc_go && acc_wr) begin
            wstage_q <= wmerge; // [RL13]
         end
         if (state_q == HBI_READ_WAIT && reg_ack_in) begin
            rstage_q <= reg_rdata_in; // [RL13]
         end
      end
   end

   // ==========================================================
   // internal register requests
   // ==========================================================
   always_ff @(posedge clock_in or negedge master_reset_n_in) begin
      if (!master_reset_n_in) begin
         reg_addr_out  <= '0;
         reg_wdata_out <= QUAD_RST;
         reg_wr_out    <= 1'b0;
         reg_rd_out    <= 1'b0;
      end else if (!rst_b_in) begin
         reg_addr_out  <= '0;
         reg_wdata_out <= QUAD_RST;
         reg_wr_out    <= 1'b0;
         reg_rd_out    <= 1'b0;
      end else begin
         reg_wr_out <= 1'b0;
         reg_rd_out <= 1'b0;
         if (state_q == HBI_IDLE && acc_go && flag) begin
            reg_addr_out <= addr_eff[ADDR_W-1:2];
            if (acc_wr) begin
               reg_wdata_out <= wmerge; // [RL3] [RL5]
               reg_wr_out    <= 1'b1;
            end else begin
               reg_rd_out    <= 1'b1; // [RL6]
            end
         end
      end
   end

   // ==========================================================
   // host pins
   // ==========================================================
   logic [BYTE_W-1:0] rd_lo;
   logic [BYTE_W-1:0] rd_hi;
   logic              drive;

   always_comb begin
      if (wide) begin
         rd_lo = addr_eff[1] ? rstage_q[2*BYTE_W +: BYTE_W]
                             : rstage_q[0 +: BYTE_W];
         rd_hi = addr_eff[1] ? rstage_q[3*BYTE_W +: BYTE_W]
                             : rstage_q[BYTE_W +: BYTE_W];
      end else begin
         rd_lo = rstage_q[addr_eff[1:0]*BYTE_W +: BYTE_W];
         rd_hi = BYTE_RST;
      end
   end

   assign drive = (state_q == HBI_HOLD) && !is_wr_q && !acc_rel;

   always_ff @(posedge clock_in or negedge master_reset_n_in) begin
      if (!master_reset_n_in) begin
         host_addr_data_low_out    <= BYTE_RST;
         host_addr_data_low_oe_out <= 1'b0;
         host_data_high_out        <= BYTE_RST;
         host_data_high_oe_out     <= 1'b0;
      end else if (!rst_b_in) begin
         host_addr_data_low_out    <= BYTE_RST;
         host_addr_data_low_oe_out <= 1'b0;
         host_data_high_out        <= BYTE_RST;
         host_data_high_oe_out     <= 1'b0;
      end else begin
         host_addr_data_low_out    <= rd_lo;
         host_addr_data_low_oe_out <= drive; // [RL1] [RL6]
         host_data_high_out        <= rd_hi;
         host_data_high_oe_out     <= drive && wide; // [RL2]
      end
   end

   // stall rises as an access is taken, falls with data driven
   always_ff @(posedge clock_in or negedge master_reset_n_in) begin
      if (!master_reset_n_in) begin
         host_stall_out <= 1'b0;
      end else if (!rst_b_in) begin
         host_stall_out <= 1'b0;
      end else if (state_q == HBI_IDLE && acc_go) begin
         host_stall_out <= 1'b1; // [RL9]
      end else if (state_q == HBI_HOLD) begin
         host_stall_out <= 1'b0; // [RL9]
      end
   end

   // open drain: level always low, enable while pending
   always_ff @(posedge clock_in or negedge master_reset_n_in) begin
      if (!master_reset_n_in) begin
         host_irq_n_out    <= 1'b0;
         host_irq_n_oe_out <= 1'b0;
      end else if (!rst_b_in) begin
         host_irq_n_out    <= 1'b0;
         host_irq_n_oe_out <= 1'b0;
      end else begin
         host_irq_n_out    <= 1'b0;
         host_irq_n_oe_out <= irq_pending_in; // [RL7]
      end
   end

endmodule

`default_nettype wire

// ==== hbi_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module hbi_checker (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic master_reset_n_in,
   input wire logic host_select_n_in,
   input wire logic host_write_strobe_n_in,
   input wire logic quadlet_boundary_flag_in,
   input wire logic width_select_in,
   input wire logic host_addr_data_low_oe_out,
   input wire logic host_data_high_oe_out,
   input wire logic host_stall_out,
   input wire logic host_irq_n_out,
   input wire logic host_irq_n_oe_out,
   input wire logic reg_wr_out,
   input wire logic reg_rd_out,
   input wire logic reg_ack_in,
   input wire logic irq_pending_in
);
   // =========
   // properties
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in || !master_reset_n_in);
   property p_wr_sel;
      reg_wr_out |-> !$past(host_select_n_in, 3);
   endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("wr no sel");
   property p_rd_wr;
      reg_rd_out |-> $past(host_write_strobe_n_in, 3);
   endproperty
   a_rd_wr: assert property (p_rd_wr) else $error("rd on wr");
   property p_wr_flag;
      reg_wr_out |-> $past(quadlet_boundary_flag_in, 3);
   endproperty
   a_wr_flag: assert property (p_wr_flag) else $error("wr no flag");
   property p_stall_req;
      reg_wr_out || reg_rd_out |-> host_stall_out;
   endproperty
   a_stall_req: assert property (p_stall_req) else $error("no stall");
   property p_stall_ack;
      reg_ack_in |-> ##[1:3] !host_stall_out;
   endproperty
   a_stall_ack: assert property (p_stall_ack) else $error("stuck");
   property p_hi_oe;
      host_data_high_oe_out |-> $past(width_select_in, 3);
   endproperty
   a_hi_oe: assert property (p_hi_oe) else $error("hi in 8b");
   property p_oe_stall;
      host_addr_data_low_oe_out |-> !host_stall_out;
   endproperty
   a_oe_stall: assert property (p_oe_stall) else $error("oe early");
   property p_irq;
      host_irq_n_oe_out == $past(irq_pending_in) && !host_irq_n_out;
   endproperty
   a_irq: assert property (p_irq) else $error("irq pin");
   property p_mrst;
      disable iff (!rst_b_in)
      !master_reset_n_in |-> !host_stall_out && !host_irq_n_oe_out;
   endproperty
   a_mrst: assert property (p_mrst) else $error("mrst");
   c_wr: cover property (reg_wr_out);
   c_rd: cover property (reg_rd_out);
   c_hi: cover property (host_data_high_oe_out);
endmodule
bind hbi_host_port hbi_checker u_chk (.clock_in, .rst_b_in,
   .master_reset_n_in, .host_select_n_in, .host_write_strobe_n_in,
   .quadlet_boundary_flag_in, .width_select_in, .host_addr_data_low_oe_out,
   .host_data_high_oe_out, .host_stall_out, .host_irq_n_out,
   .host_irq_n_oe_out, .reg_wr_out, .reg_rd_out, .reg_ack_in,
   .irq_pending_in);
`default_nettype wire

// ==== hbi_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module hbi_host_model (
   input  wire logic       clk_in,
   input  wire logic       mux_in,
   input  wire logic       stall_in,
   input  wire logic [7:0] ad_in,
   input  wire logic [7:0] dhi_in,
   output logic            sel_n_out,
   output logic            wr_n_out,
   output logic            rd_n_out,
   output logic            ale_out,
   output logic            flag_out,
   output logic      [7:0] addr_out,
   output logic      [7:0] ad_out,
   output logic      [7:0] dhi_out
);
   initial begin
      {sel_n_out, wr_n_out, rd_n_out, ale_out, flag_out} = 5'h1c;
      {addr_out, ad_out, dhi_out} = 24'h0;
   end
   task automatic acc(input logic wr, rdlo, sel, flg,
                      input logic [7:0] a, input logic [15:0] wd,
                      output logic [15:0] rd);
      int n;
      n = 0;
      addr_out <= mux_in ? ~a : a;
      if (mux_in) begin
         @(posedge clk_in);
         ad_out <= a;
         ale_out <= 1'b1;
         repeat (3) @(posedge clk_in);
         ale_out <= 1'b0;
      end
      @(posedge clk_in);
      sel_n_out <= !sel;
      wr_n_out <= !wr;
      rd_n_out <= wr && !rdlo;
      flag_out <= flg;
      ad_out <= wr ? wd[7:0] : ~ad_out;
      dhi_out <= wr ? wd[15:8] : ~dhi_out;
      // stall from the take is only settled three edges after this
      repeat (4) @(posedge clk_in);
      while (stall_in === 1'b1 && n < 60) begin
         @(posedge clk_in);
         n++;
      end
      rd = {dhi_in, ad_in};
      sel_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      flag_out <= 1'b0;
      ad_out <= ~ad_out;
      repeat (4) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// ==== hbi_host_port_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module hbi_host_port_tb;
   import hbi_pkg::*;
   logic        clk = 1'b0, rst_b = 1'b0, mrst_n = 1'b1, ack = 1'b0;
   logic        wid = 1'b0, mux = 1'b0, irq = 1'b0;
   logic [31:0] rdat = 32'h0;
   logic [31:0] mem [64];
   int          cnt = 0, wr_cnt = 0, rd_cnt = 0, cyc = 0, st_cnt = 0;
   int          fail_count = 0, tests_run = 0;
   logic        sel_n, wr_n, rd_n, ale, flg, ad_oe, dhi_oe, stall;
   logic        irq_o, irq_oe, rwr, rrd;
   logic [7:0]  addr, h_ad, h_dhi, ad_o, dhi_o;
   logic [5:0]  radr;
   logic [31:0] wdat;
   logic [15:0] r;
   wire  logic [7:0] ad_w = ad_oe ? ad_o : h_ad;
   wire  logic [7:0] dhi_w = dhi_oe ? dhi_o : h_dhi;
   initial forever #50 clk = ~clk;
   hbi_host_port DUT (.clock_in(clk), .rst_b_in(rst_b),
      .master_reset_n_in(mrst_n), .host_select_n_in(sel_n),
      .host_write_strobe_n_in(wr_n), .host_read_strobe_n_in(rd_n),
      .address_latch_strobe_in(ale), .quadlet_boundary_flag_in(flg),
      .width_select_in(wid), .multiplex_select_in(mux),
      .host_addr_low_in(addr), .host_addr_data_low_in(ad_w),
      .host_addr_data_low_out(ad_o), .host_addr_data_low_oe_out(ad_oe),
      .host_data_high_in(dhi_w), .host_data_high_out(dhi_o),
      .host_data_high_oe_out(dhi_oe), .host_stall_out(stall),
      .host_irq_n_out(irq_o), .host_irq_n_oe_out(irq_oe),
      .reg_addr_out(radr), .reg_wdata_out(wdat), .reg_wr_out(rwr),
      .reg_rd_out(rrd), .reg_rdata_in(rdat), .reg_ack_in(ack),
      .irq_pending_in(irq));
   hbi_host_model HOST (.clk_in(clk), .mux_in(mux), .stall_in(stall),
      .ad_in(ad_w), .dhi_in(dhi_w), .sel_n_out(sel_n), .wr_n_out(wr_n),
      .rd_n_out(rd_n), .ale_out(ale), .flag_out(flg), .addr_out(addr),
      .ad_out(h_ad), .dhi_out(h_dhi));
   // ==========
   // register store, acks two cycles after each request
   always @(posedge clk) begin
      ack <= (cnt == 1);
      if (cnt > 0) cnt <= cnt - 1;
      if (stall === 1'b1) st_cnt <= st_cnt + 1;
      if (rwr === 1'b1) begin
         mem[radr] <= wdat;
         cnt <= 2;
         wr_cnt <= wr_cnt + 1;
      end
      if (rrd === 1'b1) begin
         rdat <= mem[radr];
         cnt <= 2;
         rd_cnt <= rd_cnt + 1;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, a);
      tests_run++;
      if (a !== e) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, a);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_irq;
      irq <= 1'b1;
      repeat (2) @(posedge clk);
      chk("irq_oe", 1, irq_oe);
      chk("irq_lvl", 0, irq_o);
      mrst_n <= 1'b0;
      irq <= 1'b0;
      #20 chk("irq_oe_mrst", 0, irq_oe);
      @(posedge clk);
      mrst_n <= 1'b1;
      repeat (3) @(posedge clk);
      $display("t_irq end");
   endtask
   task automatic t_w8;
      int w0;
      w0 = wr_cnt;
      for (int i = 0; i < 4; i++)
         HOST.acc(1, 0, 1, i == 3, 8'h14 + 8'(i),
                  {8'ha5, 8'h11 * 8'(i + 1)}, r);
      chk("quad5", 32'h44332211, mem[5]);
      chk("wr_pulses", 1, wr_cnt - w0);
      for (int i = 0; i < 4; i++) begin
         HOST.acc(0, 0, 1, i == 0, 8'h14 + 8'(i), 16'h0, r);
         chk("rd8", 8'h11 * 8'(i + 1), r[7:0]);
      end
      $display("t_w8 end");
   endtask
   task automatic t_m16;
      wid <= 1'b1;
      mux <= 1'b1;
      repeat (3) @(posedge clk);
      HOST.acc(1, 0, 1, 0, 8'h24, 16'hbeef, r);
      HOST.acc(1, 0, 1, 1, 8'h26, 16'hcafe, r);
      chk("quad9", 32'hcafebeef, mem[9]);
      HOST.acc(0, 0, 1, 1, 8'h24, 16'h0, r);
      chk("rd16a", 16'hbeef, r);
      HOST.acc(0, 0, 1, 0, 8'h26, 16'h0, r);
      chk("rd16b", 16'hcafe, r);
      wid <= 1'b0;
      mux <= 1'b0;
      repeat (3) @(posedge clk);
      $display("t_m16 end");
   endtask
   task automatic t_ctl;
      int w0, r0, s0;
      w0 = wr_cnt;
      r0 = rd_cnt;
      s0 = st_cnt;
      HOST.acc(1, 0, 0, 1, 8'h30, 16'h0077, r);
      chk("nosel_wr", 0, wr_cnt - w0);
      chk("nosel_stall", 0, st_cnt - s0);
      s0 = st_cnt;
      HOST.acc(1, 1, 1, 1, 8'h30, 16'h005a, r);
      // take, request, two-edge store ack, hold: five stall cycles
      chk("stall_cyc", 5, st_cnt - s0);
      chk("both_wr", 8'h5a, mem[12][7:0]);
      chk("both_rd", 0, rd_cnt - r0);
      $display("t_ctl end");
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         close_out;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      t_irq;
      t_w8;
      t_m16;
      t_ctl;
      close_out;
   end
endmodule
`default_nettype wire
